// file: logic/uart_reset_channel.sv
// One UART channel with its documented reset state behind an AXI4-Lite slave.
// Operation
// - Power-up loads divisor high 00, low 01.
// - Reset pin leaves both divisor bytes unchanged.
// - Interrupt source reads 01 after reset.
// - Line status reads 60 after reset.
// - Modem status: changes cleared, inputs inverted.
// - Scratch pad reads FF after reset.
// - Reset zeroes control and feature registers, except enhanced mode, which loads 80.
// - Reset zeroes flow characters and trigger count.
// - Holding registers have no reset value.
// - Reset drives serial, modem outputs per table.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module uart_reset_channel (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        powerUpN,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   input  wire logic [3:0]  modemInN,
   output var  logic        serialOut,
   output var  logic        generalOutputTwoN,
   output var  logic        rtsN,
   output var  logic        dtrN,
   output var  logic        receiveReadyN,
   output var  logic        transmitReadyN,
   output var  logic        interruptOut
);

   logic [7:0]  divHigh_reg, divLow_reg, fraction_reg, altFunc_reg;
   logic [7:0]  intEnable_reg, fifoCtrl_reg, lineCtrl_reg, modemCtrl_reg;
   logic [7:0]  scratch_reg, feature_reg, enhMode_reg;
   logic [7:0]  resume1_reg, resume2_reg, pause1_reg, pause2_reg;
   logic [7:0]  holdTx_reg, holdRx_reg;
   logic [7:0]  intSource_reg, lineStatus_reg, fifoLevel_reg, trigCount_reg;
   logic [3:0]  modemDelta_reg;
   logic [3:0]  modemS1_reg, modemS2_reg, modemS3_reg, modemStable_reg;
   logic [1:0]  powerCount_reg;
   logic        powerDone_reg;
   logic [7:0]  awaddr_reg;
   logic [7:0]  wbyte_reg;
   logic        awHave_reg, wHave_reg, wLane_reg;
   uart_reset_pkg::bus_state_t busState_reg;
   uart_reset_pkg::modem_out_t modemOut;
   logic        doWrite;
   logic [7:0]  readByte;
   logic        readHit;
   logic [3:0]  modemChange;
   logic        statusRead;

   // Decodes whether an address is a mapped register.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= uart_reset_pkg::OFF_TRIGGER_COUNT);
   endfunction : mapped

   assign doWrite = (busState_reg == uart_reset_pkg::BUS_IDLE) && awHave_reg && wHave_reg;

   // Power-up sequencing: the divisor is loaded in the next block while powerUpN is low, not by nrst.
   always_ff @(posedge clock) begin
      if (!powerUpN) begin
         powerCount_reg <= 2'h0;
         powerDone_reg  <= 1'b0;
      end else if (!powerDone_reg) begin
         powerCount_reg <= powerCount_reg + 2'h1;
         powerDone_reg  <= (powerCount_reg == uart_reset_pkg::POWER_UP_CYCLES);
      end
   end

   // Baud divisor bytes.
   always_ff @(posedge clock) begin
      if (!powerUpN) begin
         divHigh_reg <= uart_reset_pkg::RST_DIVISOR_HIGH;
         divLow_reg  <= uart_reset_pkg::RST_DIVISOR_LOW;
      end else if (doWrite && nrst && wLane_reg) begin
         if (awaddr_reg == uart_reset_pkg::OFF_DIVISOR_HIGH) begin
            divHigh_reg <= wbyte_reg;
         end
         if (awaddr_reg == uart_reset_pkg::OFF_DIVISOR_LOW) begin
            divLow_reg <= wbyte_reg;
         end
      end
   end

   // Software-written control registers.
   always_ff @(posedge clock) begin
      if (!nrst || !powerUpN) begin
         fraction_reg  <= uart_reset_pkg::RST_ZERO;
         altFunc_reg   <= uart_reset_pkg::RST_ZERO;
         intEnable_reg <= uart_reset_pkg::RST_ZERO;
         fifoCtrl_reg  <= uart_reset_pkg::RST_ZERO;
         lineCtrl_reg  <= uart_reset_pkg::RST_ZERO;
         modemCtrl_reg <= uart_reset_pkg::RST_ZERO;
         feature_reg   <= uart_reset_pkg::RST_ZERO;
         scratch_reg   <= uart_reset_pkg::RST_SCRATCH_PAD;
         enhMode_reg   <= uart_reset_pkg::RST_ENHANCED_MODE;
         resume1_reg   <= uart_reset_pkg::RST_ZERO;
         resume2_reg   <= uart_reset_pkg::RST_ZERO;
         pause1_reg    <= uart_reset_pkg::RST_ZERO;
         pause2_reg    <= uart_reset_pkg::RST_ZERO;
      end else if (doWrite && wLane_reg) begin
         case (awaddr_reg)
            uart_reset_pkg::OFF_FRACTIONAL:       fraction_reg  <= wbyte_reg;
            uart_reset_pkg::OFF_ALT_FUNCTION:     altFunc_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_INTERRUPT_ENABLE: intEnable_reg <= wbyte_reg;
            uart_reset_pkg::OFF_FIFO_CONTROL:     fifoCtrl_reg  <= wbyte_reg;
            uart_reset_pkg::OFF_LINE_CONTROL:     lineCtrl_reg  <= wbyte_reg;
            uart_reset_pkg::OFF_MODEM_CONTROL:    modemCtrl_reg <= wbyte_reg;
            uart_reset_pkg::OFF_ENHANCED_FEATURE: feature_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_SCRATCH_PAD:      scratch_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_ENHANCED_MODE:    enhMode_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_RESUME_ONE:       resume1_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_RESUME_TWO:       resume2_reg   <= wbyte_reg;
            uart_reset_pkg::OFF_PAUSE_ONE:        pause1_reg    <= wbyte_reg;
            uart_reset_pkg::OFF_PAUSE_TWO:        pause2_reg    <= wbyte_reg;
            default: ;
         endcase
      end
   end

   // Holding registers carry no reset value.
   always_ff @(posedge clock) begin
      if (doWrite && wLane_reg && nrst && awaddr_reg == uart_reset_pkg::OFF_RECEIVE_HOLDING) begin
         holdTx_reg <= wbyte_reg;
      end
      holdRx_reg <= holdRx_reg;
   end

   // Status registers held at their reset pattern.
   always_ff @(posedge clock) begin
      if (!nrst || !powerUpN) begin
         intSource_reg  <= uart_reset_pkg::RST_INTERRUPT_SOURCE;
         lineStatus_reg <= uart_reset_pkg::RST_LINE_STATUS;
         fifoLevel_reg  <= uart_reset_pkg::RST_ZERO;
         trigCount_reg  <= uart_reset_pkg::RST_ZERO;
      end
   end

   // Modem input synchroniser and change detection.
   always_ff @(posedge clock) begin
      modemS1_reg <= modemInN;
      modemS2_reg <= modemS1_reg;
      modemS3_reg <= modemS2_reg;
   end

   // A settled change is recorded; a status read clears, but a change in that cycle wins.
   assign modemChange = (modemS2_reg == modemS3_reg) ? (modemStable_reg ^ modemS3_reg) : 4'h0;
   assign statusRead  = (busState_reg == uart_reset_pkg::BUS_IDLE) && !doWrite && arvalid &&
                        !arready && (araddr == uart_reset_pkg::OFF_MODEM_STATUS);

   always_ff @(posedge clock) begin
      if (!nrst || !powerUpN) begin
         modemDelta_reg  <= 4'h0;
         modemStable_reg <= modemS3_reg;
      end else begin
         if (modemS2_reg == modemS3_reg) begin
            modemStable_reg <= modemS3_reg;
         end
         modemDelta_reg <= (statusRead ? 4'h0 : modemDelta_reg) | modemChange;
      end
   end

   // Read multiplexer.
   always_comb begin
      readHit = mapped(araddr);
      case (araddr)
         uart_reset_pkg::OFF_RECEIVE_HOLDING:  readByte = holdRx_reg;
         uart_reset_pkg::OFF_INTERRUPT_ENABLE: readByte = intEnable_reg;
         uart_reset_pkg::OFF_INTERRUPT_SOURCE: readByte = intSource_reg;
         uart_reset_pkg::OFF_LINE_CONTROL:     readByte = lineCtrl_reg;
         uart_reset_pkg::OFF_MODEM_CONTROL:    readByte = modemCtrl_reg;
         uart_reset_pkg::OFF_LINE_STATUS:      readByte = lineStatus_reg;
         uart_reset_pkg::OFF_MODEM_STATUS:     readByte = {~modemStable_reg, modemDelta_reg};
         uart_reset_pkg::OFF_SCRATCH_PAD:      readByte = scratch_reg;
         uart_reset_pkg::OFF_DIVISOR_LOW:      readByte = divLow_reg;
         uart_reset_pkg::OFF_DIVISOR_HIGH:     readByte = divHigh_reg;
         uart_reset_pkg::OFF_FRACTIONAL:       readByte = fraction_reg;
         uart_reset_pkg::OFF_ALT_FUNCTION:     readByte = altFunc_reg;
         uart_reset_pkg::OFF_ENHANCED_FEATURE: readByte = feature_reg;
         uart_reset_pkg::OFF_RESUME_ONE:       readByte = resume1_reg;
         uart_reset_pkg::OFF_RESUME_TWO:       readByte = resume2_reg;
         uart_reset_pkg::OFF_PAUSE_ONE:        readByte = pause1_reg;
         uart_reset_pkg::OFF_PAUSE_TWO:        readByte = pause2_reg;
         uart_reset_pkg::OFF_FIFO_LEVEL:       readByte = fifoLevel_reg;
         uart_reset_pkg::OFF_TRIGGER_COUNT:    readByte = trigCount_reg;
         default:                              readByte = 8'h00;
      endcase
   end

   // AXI4-Lite write address and data capture.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         awHave_reg <= 1'b0;
         wHave_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wbyte_reg  <= 8'h00;
         wLane_reg  <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awHave_reg <= 1'b1;
            awaddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_reg <= 1'b1;
            wbyte_reg <= wdata[7:0];
            wLane_reg <= wstrb[0];
         end
         if (doWrite) begin
            awHave_reg <= 1'b0;
            wHave_reg  <= 1'b0;
         end
      end
   end

   // AXI4-Lite handshake state machine.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         busState_reg <= uart_reset_pkg::BUS_IDLE;
         awready      <= 1'b0;
         wready       <= 1'b0;
         arready      <= 1'b0;
         bvalid       <= 1'b0;
         bresp        <= uart_reset_pkg::RESP_OKAY;
         rvalid       <= 1'b0;
         rresp        <= uart_reset_pkg::RESP_OKAY;
         rdata        <= 32'h0000_0000;
      end else begin
         awready <= 1'b0;
         wready  <= 1'b0;
         arready <= 1'b0;
         case (busState_reg)
            uart_reset_pkg::BUS_IDLE: begin
               if (doWrite) begin
                  bvalid       <= 1'b1;
                  bresp        <= mapped(awaddr_reg) ? uart_reset_pkg::RESP_OKAY
                                                     : uart_reset_pkg::RESP_SLVERR;
                  busState_reg <= uart_reset_pkg::BUS_WRESP;
               end else if (arvalid && !arready) begin
                  arready      <= 1'b1;
                  rvalid       <= 1'b1;
                  rdata        <= {24'h00_0000, readByte};
                  rresp        <= readHit ? uart_reset_pkg::RESP_OKAY
                                          : uart_reset_pkg::RESP_SLVERR;
                  busState_reg <= uart_reset_pkg::BUS_RRESP;
               end else begin
                  awready <= awvalid && !awHave_reg && !awready;
                  wready  <= wvalid && !wHave_reg && !wready;
               end
            end
            uart_reset_pkg::BUS_WRESP: begin
               if (bready) begin
                  bvalid       <= 1'b0;
                  busState_reg <= uart_reset_pkg::BUS_IDLE;
               end
            end
            uart_reset_pkg::BUS_RRESP: begin
               if (rready) begin
                  rvalid       <= 1'b0;
                  busState_reg <= uart_reset_pkg::BUS_IDLE;
               end
            end
            default: busState_reg <= uart_reset_pkg::BUS_IDLE;
         endcase
      end
   end

   // Pin outputs: modem-control bits drive the active-low pins.
   assign modemOut.dtrN              = ~modemCtrl_reg[uart_reset_pkg::MCR_DTR];
   assign modemOut.rtsN              = ~modemCtrl_reg[uart_reset_pkg::MCR_RTS];
   assign modemOut.generalOutputTwoN = ~modemCtrl_reg[uart_reset_pkg::MCR_OP2];

   always_ff @(posedge clock) begin
      if (!nrst || !powerUpN) begin
         serialOut         <= 1'b1;
         generalOutputTwoN <= 1'b1;
         rtsN              <= 1'b1;
         dtrN              <= 1'b1;
         receiveReadyN     <= 1'b1;
         transmitReadyN    <= 1'b0;
         interruptOut      <= 1'b0;
      end else begin
         serialOut         <= ~lineCtrl_reg[uart_reset_pkg::LCR_BREAK];
         generalOutputTwoN <= modemOut.generalOutputTwoN;
         rtsN              <= modemOut.rtsN;
         dtrN              <= modemOut.dtrN;
         receiveReadyN     <= 1'b1;
         transmitReadyN    <= 1'b0;
         interruptOut      <= 1'b0;
      end
   end

   // Assertions.
   a_divisor_powerup: assert property (@(posedge clock)
      $rose(powerUpN) |-> divHigh_reg == 8'h00 && divLow_reg == 8'h01)
      else $error("Divisor not loaded at power-up.");

   a_divisor_keep: assert property (@(posedge clock) disable iff (!powerUpN)
      !nrst |=> $stable(divHigh_reg) && $stable(divLow_reg))
      else $error("Divisor changed under reset pin.");

   a_source_reset: assert property (@(posedge clock)
      $rose(nrst) |-> intSource_reg == 8'h01)
      else $error("Interrupt source not 01 after reset.");

   a_line_reset: assert property (@(posedge clock)
      $rose(nrst) |-> lineStatus_reg == 8'h60)
      else $error("Line status not 60 after reset.");

   a_modem_delta: assert property (@(posedge clock)
      $rose(nrst) |-> modemDelta_reg == 4'h0)
      else $error("Modem changes not cleared.");

   a_scratch_reset: assert property (@(posedge clock)
      $rose(nrst) |-> scratch_reg == 8'hFF)
      else $error("Scratch pad not FF after reset.");

   a_ctrl_zero: assert property (@(posedge clock)
      $rose(nrst) |-> (lineCtrl_reg | modemCtrl_reg | feature_reg | intEnable_reg) == 8'h00)
      else $error("Control registers not cleared.");

   a_flow_zero: assert property (@(posedge clock)
      $rose(nrst) |-> (resume1_reg | resume2_reg | pause1_reg | pause2_reg) == 8'h00)
      else $error("Flow characters not cleared.");

   sequence held_reset;
      !nrst ##1 !nrst ##1 !nrst;
   endsequence

   a_pins_reset: assert property (@(posedge clock)
      held_reset |-> serialOut && rtsN && dtrN && generalOutputTwoN && receiveReadyN
                     && !transmitReadyN && !interruptOut)
      else $error("Pins not at reset levels.");

   a_held_reset: assert property (@(posedge clock)
      held_reset |-> !bvalid && !rvalid && $stable(scratch_reg))
      else $error("State moved during held reset.");

endmodule : uart_reset_channel
`default_nettype wire

// file: logic/uart_reset_pkg.sv
// Package with register map, reset values and carrier types of the reset-state UART channel.
package uart_reset_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [7:0] OFF_RECEIVE_HOLDING  = 8'h00;
   localparam logic [7:0] OFF_INTERRUPT_ENABLE = 8'h04;
   localparam logic [7:0] OFF_INTERRUPT_SOURCE = 8'h08;
   localparam logic [7:0] OFF_LINE_CONTROL     = 8'h0C;
   localparam logic [7:0] OFF_MODEM_CONTROL    = 8'h10;
   localparam logic [7:0] OFF_LINE_STATUS      = 8'h14;
   localparam logic [7:0] OFF_MODEM_STATUS     = 8'h18;
   localparam logic [7:0] OFF_SCRATCH_PAD      = 8'h1C;
   localparam logic [7:0] OFF_DIVISOR_LOW      = 8'h20;
   localparam logic [7:0] OFF_DIVISOR_HIGH     = 8'h24;
   localparam logic [7:0] OFF_FRACTIONAL       = 8'h28;
   localparam logic [7:0] OFF_ALT_FUNCTION     = 8'h2C;
   localparam logic [7:0] OFF_FIFO_CONTROL     = 8'h30;
   localparam logic [7:0] OFF_ENHANCED_FEATURE = 8'h34;
   localparam logic [7:0] OFF_RESUME_ONE       = 8'h38;
   localparam logic [7:0] OFF_RESUME_TWO       = 8'h3C;
   localparam logic [7:0] OFF_PAUSE_ONE        = 8'h40;
   localparam logic [7:0] OFF_PAUSE_TWO        = 8'h44;
   localparam logic [7:0] OFF_FIFO_LEVEL       = 8'h48;
   localparam logic [7:0] OFF_ENHANCED_MODE    = 8'h4C;
   localparam logic [7:0] OFF_TRIGGER_COUNT    = 8'h50;

   // Reset values.
   localparam logic [7:0] RST_DIVISOR_HIGH     = 8'h00;
   localparam logic [7:0] RST_DIVISOR_LOW      = 8'h01;
   localparam logic [7:0] RST_ZERO             = 8'h00;
   localparam logic [7:0] RST_INTERRUPT_SOURCE = 8'h01;
   localparam logic [7:0] RST_LINE_STATUS      = 8'h60;
   localparam logic [7:0] RST_SCRATCH_PAD      = 8'hFF;
   localparam logic [7:0] RST_ENHANCED_MODE    = 8'h80;

   // Modem control field positions.
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_OP2 = 3;

   // Line control break bit, which forces the serial output low.
   localparam int LCR_BREAK = 6;

   // AXI4-Lite responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power-up count at which powerDone_reg is set; the divisor is loaded while powerUpN is low, without waiting for it.
   localparam logic [1:0] POWER_UP_CYCLES = 2'h2;

   // Modem-control output group.
   typedef struct packed {
      logic dtrN;
      logic rtsN;
      logic generalOutputTwoN;
   } modem_out_t;

   // Bus handshake states.
   typedef enum logic [2:0] {
      BUS_IDLE  = 3'b001,
      BUS_WRESP = 3'b010,
      BUS_RRESP = 3'b100
   } bus_state_t;

endpackage : uart_reset_pkg

// file: verif/serial_line_model.sv
// Serial line partner that drives the modem inputs of the channel.
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
   input  wire logic       clock,
   input  wire logic       lineIn,
   output var  logic [3:0] modemOutN
);
   initial begin
      modemOutN = 4'hA;
   end

   // Changes the modem levels just after a clock edge.
   task automatic setModem(input logic [3:0] value);
      @(posedge clock);
      modemOutN <= value;
   endtask : setModem
endmodule : serial_line_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench for the reset state of one UART channel.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clock, nrst, powerUpN, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, serialOut, generalOutputTwoN, rtsN, dtrN;
   logic        receiveReadyN, transmitReadyN, interruptOut;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, readData;
   logic [3:0]  wstrb, modemInN;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] pins;
   int          failures;
   int          comparisons;

   localparam logic [7:0] OFFS [15] = '{uart_reset_pkg::OFF_INTERRUPT_ENABLE,
      uart_reset_pkg::OFF_INTERRUPT_SOURCE, uart_reset_pkg::OFF_LINE_CONTROL,
      uart_reset_pkg::OFF_MODEM_CONTROL, uart_reset_pkg::OFF_LINE_STATUS,
      uart_reset_pkg::OFF_SCRATCH_PAD, uart_reset_pkg::OFF_FRACTIONAL,
      uart_reset_pkg::OFF_ALT_FUNCTION, uart_reset_pkg::OFF_ENHANCED_FEATURE,
      uart_reset_pkg::OFF_RESUME_ONE, uart_reset_pkg::OFF_RESUME_TWO,
      uart_reset_pkg::OFF_PAUSE_ONE, uart_reset_pkg::OFF_PAUSE_TWO,
      uart_reset_pkg::OFF_FIFO_LEVEL, uart_reset_pkg::OFF_TRIGGER_COUNT};
   localparam logic [7:0] RSTV [15] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hFF, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   assign pins = {25'h0000000, serialOut, generalOutputTwoN, rtsN, dtrN, receiveReadyN,
                  transmitReadyN, interruptOut};

   uart_reset_channel dut_u (
      .clock(clock), .nrst(nrst), .powerUpN(powerUpN), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .modemInN(modemInN), .serialOut(serialOut), .generalOutputTwoN(generalOutputTwoN),
      .rtsN(rtsN), .dtrN(dtrN), .receiveReadyN(receiveReadyN),
      .transmitReadyN(transmitReadyN), .interruptOut(interruptOut)
   );

   serial_line_model line_u (.clock(clock), .lineIn(serialOut), .modemOutN(modemInN));

   always #25 clock = ~clock;

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Offers address and data together and releases each when it is taken.
   task automatic busWrite(input logic [7:0] addr, input logic [7:0] data);
      int n;
      @(posedge clock);
      awaddr <= addr;
      awvalid <= 1'h1;
      wdata <= {24'h000000, data};
      wvalid <= 1'h1;
      bready <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid && n < 100);
      resp = bresp;
      bready <= 1'h0;
      if (n >= 100) failures++;
   endtask : busWrite

   task automatic busRead(input logic [7:0] addr);
      int n;
      @(posedge clock);
      araddr <= addr;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid && n < 100);
      readData = rdata;
      resp = rresp;
      rready <= 1'h0;
      if (n >= 100) failures++;
   endtask : busRead

   // Holds reset for 12 cycles and watches the pins while it is held.
   task automatic applyReset(input logic powerUp);
      @(posedge clock);
      nrst <= 1'h0;
      powerUpN <= ~powerUp;
      for (int i = 0; i < 12; i++) begin
         @(posedge clock);
         if (i >= 3) check("pins in reset", 32'h0000007C, pins);
      end
      nrst <= 1'h1;
      powerUpN <= 1'h1;
   endtask : applyReset

   task automatic checkTable(input logic [7:0] low, input logic [7:0] high, input logic [7:0] ms);
      check("pins after reset", 32'h0000007C, pins);
      for (int i = 0; i < 15; i++) begin
         busRead(OFFS[i]);
         check($sformatf("register %h", OFFS[i]), {24'h000000, RSTV[i]}, readData);
      end
      busRead(uart_reset_pkg::OFF_DIVISOR_LOW);
      check("divisor low", {24'h000000, low}, readData);
      busRead(uart_reset_pkg::OFF_DIVISOR_HIGH);
      check("divisor high", {24'h000000, high}, readData);
      busRead(uart_reset_pkg::OFF_MODEM_STATUS);
      check("modem status", {24'h000000, ms}, readData);
   endtask : checkTable

   initial begin
      clock = 1'h0;
      nrst = 1'h0;
      powerUpN = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'hF;
      failures = 0;
      comparisons = 0;
      applyReset(1'h1);
      checkTable(8'h01, 8'h00, 8'h50);
      busWrite(uart_reset_pkg::OFF_DIVISOR_LOW, 8'h34);
      busWrite(uart_reset_pkg::OFF_DIVISOR_HIGH, 8'h12);
      for (int i = 0; i < 15; i++) begin
         busWrite(OFFS[i], 8'h4B);
         check("write response", {30'h00000000, uart_reset_pkg::RESP_OKAY}, {30'h00000000, resp});
      end
      busRead(uart_reset_pkg::OFF_SCRATCH_PAD);
      check("scratch written", 32'h0000004B, readData);
      check("driven pins", 32'h00000000, {29'h00000000, serialOut, generalOutputTwoN, dtrN});
      busWrite(8'h54, 8'h00);
      check("unmapped write", {30'h00000000, uart_reset_pkg::RESP_SLVERR}, {30'h00000000, resp});
      busRead(8'h05);
      check("unaligned read", {30'h00000000, uart_reset_pkg::RESP_SLVERR}, {30'h00000000, resp});
      line_u.setModem(4'h3);
      repeat (6) @(posedge clock);
      busRead(uart_reset_pkg::OFF_MODEM_STATUS);
      check("modem change", 32'h000000C9, readData);
      applyReset(1'h0);
      checkTable(8'h34, 8'h12, 8'hC0);
      applyReset(1'h1);
      checkTable(8'h01, 8'h00, 8'hC0);
      conclude();
   end

   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
